// [wrw_defs.svh]
/*
 * Offsets, field positions, reset values and timing figures of the
 * windowed reset watchdog.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef WRW_DEFS_SVH
`define WRW_DEFS_SVH

// ---------------------------------------------------------------
// Register map (index and byte address)
// ---------------------------------------------------------------
`define WRW_CTRL_IDX 8'h0D
`define WRW_STAT_IDX 8'h0E
`define WRW_CTRL_ADDR 12'h034
`define WRW_STAT_ADDR 12'h038
`define WRW_ADDR_W 12

// ---------------------------------------------------------------
// Fields and values
// ---------------------------------------------------------------
`define WRW_ACT_BIT 7
`define WRW_TOP_BIT 6
`define WRW_CTRL_RST 8'h7F
`define WRW_ROLL_VAL 7'h40
`define WRW_STAT_HW 0
`define WRW_STAT_HALT 1
`define WRW_STAT_WAKE 2
`define WRW_STAT_RST 3

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define WRW_CLK_MHZ 250
`define WRW_TICK_CYC 65536
`define WRW_RST_NS 30000
`define WRW_WAKE_CYC 514
`define WRW_PRE_W 17
`define WRW_RCNT_W 16
`define WRW_WCNT_W 10

`endif

// [wrw_pkg.sv]
/*
 * Types shared by the windowed reset watchdog.
 * Assumes nothing of its surroundings.
 */
`default_nettype none

package wrw_pkg;

    // ---------------------------------------------------------------
    // Control register image
    // ---------------------------------------------------------------
    typedef struct packed {
        logic act;
        logic [6:0] cnt;
    } wrw_ctrl_t;

    // ---------------------------------------------------------------
    // Low-power sequencing
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        WRW_RUN = 2'b00,
        WRW_HALT = 2'b01,
        WRW_WAKE = 2'b10
    } wrw_pwr_t;

endpackage : wrw_pkg

`default_nettype wire

// [wrw_watchdog.sv]
/*
 * Windowed reset watchdog: 7-bit down-counter behind an APB slave,
 * pulsing a chip reset low on expiry or on software request.
 * Assumes core_clk at 250 MHz, halt and wake from the core clock
 * domain, and the option strap held steady across reset release.
 */
// How it works
// R01: Counter drops one every 65536 cycles
// R02: Active and 40h to 3Fh fires reset
// R03: Counter runs even when not activated
// R04: Software refreshes with C0h..FFh in time
// R05: Low six bits give steps left
// R06: Option strap picks software or hardware mode
// R07: Software mode leaves reset deactivated
// R08: Activation bit cannot be cleared by software
// R09: Write active with top bit clear resets
// R10: Hardware mode is always active
// R11: WAIT mode changes nothing
// R12: HALT freezes counter, blocks reset
// R13: Wake resumes counting after 514 cycles
// R14: Reset out of HALT deactivates again
// R15: Software refreshes before entering HALT
// R16: Control reads activation and count, resets 7Fh
// R17: Write loads count, restarts interval
`include "wrw_defs.svh"
`default_nettype none

module wrw_watchdog #(
    parameter int TICK_CYC = `WRW_TICK_CYC,
    parameter int RST_CYC = (`WRW_RST_NS * `WRW_CLK_MHZ + 999) / 1000
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`WRW_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Option strap and power state
    input wire logic hw_mode_opt,
    input wire logic halt_req,
    input wire logic ext_wake,
    // Reset request to the reset pin driver
    output logic wd_rst_b
);

    // ---------------------------------------------------------------
    // Reset release and strap capture
    // ---------------------------------------------------------------
    logic rst_s1_q, rst_n_q;
    logic opt_s1_q, opt_s2_q, hw_mode_q, opt_done_q;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q <= rst_s1_q;
        end
    end

    // No reset here, so the strap has settled by the time reset lifts
    always_ff @(posedge core_clk) begin
        opt_s1_q <= hw_mode_opt;
        opt_s2_q <= opt_s1_q;
    end

    // Strap is caught once after release so a glitch later cannot drop it
    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            hw_mode_q <= 1'b0;
            opt_done_q <= 1'b0;
        end else if (!opt_done_q) begin
            hw_mode_q <= opt_s2_q; // R06
            opt_done_q <= 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // APB decode
    // ---------------------------------------------------------------
    logic setup, wr_acc, hit_ctrl, hit_stat, ctrl_wr;

    assign setup = psel && !penable;
    assign wr_acc = psel && penable && pwrite;
    assign hit_ctrl = (paddr == `WRW_CTRL_ADDR);
    assign hit_stat = (paddr == `WRW_STAT_ADDR);
    assign ctrl_wr = wr_acc && hit_ctrl;
    // Data is staged in the setup cycle, so every access takes one wait-free phase
    assign pready = 1'b1;

    // ---------------------------------------------------------------
    // Low-power sequencing
    // ---------------------------------------------------------------
    wrw_pkg::wrw_pwr_t pwr_q;
    logic [`WRW_WCNT_W-1:0] wake_q;

    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pwr_q <= wrw_pkg::WRW_RUN;
        end else begin
            case (pwr_q)
                wrw_pkg::WRW_RUN: begin
                    if (halt_req) begin
                        pwr_q <= wrw_pkg::WRW_HALT; // R12
                    end
                end
                wrw_pkg::WRW_HALT: begin
                    if (ext_wake) begin
                        pwr_q <= wrw_pkg::WRW_WAKE; // R13
                    end
                end
                wrw_pkg::WRW_WAKE: begin
                    if (wake_q == `WRW_WCNT_W'(1)) begin
                        pwr_q <= wrw_pkg::WRW_RUN; // R13
                    end
                end
                default: begin
                    pwr_q <= wrw_pkg::WRW_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            wake_q <= '0;
        end else if (pwr_q == wrw_pkg::WRW_HALT && ext_wake) begin
            wake_q <= `WRW_WCNT_W'(`WRW_WAKE_CYC); // R13
        end else if (wake_q != '0) begin
            wake_q <= wake_q - `WRW_WCNT_W'(1);
        end
    end

    logic running;

    // WAIT is not an input at all: it cannot touch the count
    assign running = (pwr_q == wrw_pkg::WRW_RUN); // R11

    // ---------------------------------------------------------------
    // Interval prescaler
    // ---------------------------------------------------------------
    logic [`WRW_PRE_W-1:0] pre_q;
    logic tick;

    assign tick = running && (pre_q == `WRW_PRE_W'(TICK_CYC - 1));

    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pre_q <= '0;
        end else if (ctrl_wr) begin
            pre_q <= '0; // R17
        end else if (tick) begin
            pre_q <= '0; // R01
        end else if (running) begin
            pre_q <= pre_q + `WRW_PRE_W'(1);
        end
    end

    // ---------------------------------------------------------------
    // Control register
    // ---------------------------------------------------------------
    wrw_pkg::wrw_ctrl_t ctrl_q;
    logic active, roll, sw_rst, trig;

    // Reset value clears activation, also for a reset that ends HALT
    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ctrl_q <= wrw_pkg::wrw_ctrl_t'(`WRW_CTRL_RST); // R16 R07 R14
        end else if (ctrl_wr) begin
            ctrl_q.act <= ctrl_q.act | pwdata[`WRW_ACT_BIT]; // R08
            ctrl_q.cnt <= pwdata[`WRW_TOP_BIT:0]; // R17 R05
        end else if (tick) begin
            ctrl_q.cnt <= ctrl_q.cnt - 7'(1); // R01 R03
        end
    end

    assign active = hw_mode_q || ctrl_q.act; // R10
    // A refresh landing on the roll cycle wins, as the write reloads the count
    assign roll = tick && !ctrl_wr && (ctrl_q.cnt == `WRW_ROLL_VAL);
    assign sw_rst = ctrl_wr && !pwdata[`WRW_TOP_BIT]
        && (hw_mode_q || pwdata[`WRW_ACT_BIT] || ctrl_q.act); // R09
    // Roll only counts while running, so HALT suppresses it
    assign trig = running && ((active && roll) || sw_rst); // R02 R12

    // ---------------------------------------------------------------
    // Reset pulse
    // ---------------------------------------------------------------
    // A retrigger reloads the pulse, so a pulse can stretch but never shorten
    logic [`WRW_RCNT_W-1:0] rcnt_q;

    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rcnt_q <= '0;
        end else if (trig) begin
            rcnt_q <= `WRW_RCNT_W'(RST_CYC); // R02
        end else if (rcnt_q != '0) begin
            rcnt_q <= rcnt_q - `WRW_RCNT_W'(1);
        end
    end

    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            wd_rst_b <= 1'b1;
        end else begin
            wd_rst_b <= !(trig || rcnt_q > `WRW_RCNT_W'(1)); // R02
        end
    end

    // ---------------------------------------------------------------
    // Read data and error
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            prdata <= '0;
            pslverr <= 1'b0;
        end else if (setup) begin
            pslverr <= !(hit_ctrl || hit_stat);
            if (hit_ctrl) begin
                prdata <= {24'h0, ctrl_q}; // R16
            end else if (hit_stat) begin
                prdata <= '0;
                prdata[`WRW_STAT_HW] <= hw_mode_q;
                prdata[`WRW_STAT_HALT] <= (pwr_q == wrw_pkg::WRW_HALT);
                prdata[`WRW_STAT_WAKE] <= (pwr_q == wrw_pkg::WRW_WAKE);
                prdata[`WRW_STAT_RST] <= !wd_rst_b;
            end else begin
                prdata <= '0;
            end
        end
    end

    // ---------------------------------------------------------------
    // Check helpers
    // ---------------------------------------------------------------
    // Cycles spent in the wake delay, counted apart from wake_q
    logic [`WRW_WCNT_W-1:0] wake_len_q;

    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            wake_len_q <= '0;
        end else if (pwr_q == wrw_pkg::WRW_WAKE) begin
            wake_len_q <= wake_len_q + `WRW_WCNT_W'(1);
        end else begin
            wake_len_q <= '0;
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n_q);

    tick_decrement_a: assert property ( // R01
        (tick && !ctrl_wr) |=> (ctrl_q.cnt == $past(ctrl_q.cnt) - 7'(1)))
        else $error("count did not drop on tick");

    tick_spacing_a: assert property ( // R01
        (tick && !ctrl_wr) |=> !tick)
        else $error("ticks too close");

    roll_reset_a: assert property ( // R02
        (running && active && roll) |=> !wd_rst_b [*8])
        else $error("expiry did not pulse reset");

    free_run_a: assert property ( // R03
        (tick && !ctrl_wr && !active) |=> (ctrl_q.cnt != $past(ctrl_q.cnt)))
        else $error("counter stopped while inactive");

    act_sticky_a: assert property ( // R08
        ctrl_q.act |=> ctrl_q.act)
        else $error("activation bit cleared");

    sw_reset_a: assert property ( // R09
        (ctrl_wr && !pwdata[`WRW_TOP_BIT] && pwdata[`WRW_ACT_BIT] && running)
        |=> !wd_rst_b ##1 !wd_rst_b)
        else $error("software reset missing");

    halt_freeze_a: assert property ( // R12
        (pwr_q == wrw_pkg::WRW_HALT && !ctrl_wr) |=> $stable(ctrl_q.cnt) && $stable(pre_q))
        else $error("counter moved in halt");

    halt_no_reset_a: assert property ( // R12
        (pwr_q != wrw_pkg::WRW_RUN && rcnt_q <= `WRW_RCNT_W'(1)) |=> wd_rst_b)
        else $error("reset raised in halt");

    wake_delay_a: assert property ( // R13
        (pwr_q == wrw_pkg::WRW_WAKE)
        |=> (running == ($past(wake_len_q) == `WRW_WCNT_W'(`WRW_WAKE_CYC - 1))))
        else $error("wake delay not 514 cycles");

    write_restart_a: assert property ( // R17
        ctrl_wr |=> (pre_q == '0) && (ctrl_q.cnt == $past(pwdata[`WRW_TOP_BIT:0])))
        else $error("write did not reload");

    refresh_safe_a: assert property ( // R09
        (ctrl_wr && pwdata[`WRW_TOP_BIT] && rcnt_q <= `WRW_RCNT_W'(1)) |=> wd_rst_b)
        else $error("refresh raised reset");

    unmapped_err_a: assert property ( // R16
        (setup && !hit_ctrl && !hit_stat) |=> pslverr)
        else $error("unmapped access without error");

    ctrl_read_a: assert property ( // R16
        (setup && hit_ctrl) |=> (prdata == {24'h0, $past(ctrl_q)}))
        else $error("control read data wrong");

    strap_hold_a: assert property ( // R06
        opt_done_q |=> $stable(hw_mode_q))
        else $error("mode strap changed after capture");

    status_read_a: assert property ( // R06
        (setup && hit_stat) |=> (prdata[`WRW_STAT_HW] == $past(hw_mode_q)))
        else $error("status mode bit wrong");

    halt_enter_a: assert property ( // R12
        (pwr_q == wrw_pkg::WRW_RUN && halt_req) |=> (pwr_q == wrw_pkg::WRW_HALT))
        else $error("halt not entered");

    wake_start_a: assert property ( // R13
        (pwr_q == wrw_pkg::WRW_HALT && ext_wake) |=> (pwr_q == wrw_pkg::WRW_WAKE))
        else $error("wake delay not started");

    count_hold_a: assert property ( // R01
        (!tick && !ctrl_wr) |=> $stable(ctrl_q.cnt))
        else $error("count moved without tick");

    act_set_a: assert property ( // R08
        (ctrl_wr && pwdata[`WRW_ACT_BIT]) |=> ctrl_q.act)
        else $error("activation bit not set");

    hw_active_a: assert property ( // R10
        (hw_mode_q && roll) |=> !wd_rst_b)
        else $error("hardware mode expiry without reset");

    pulse_hold_a: assert property ( // R02
        (rcnt_q > `WRW_RCNT_W'(1)) |=> !wd_rst_b)
        else $error("reset pulse ended early");

endmodule : wrw_watchdog

`default_nettype wire

// [test_wrw_watchdog.sv]
/*
 * Self-checking testbench of the windowed reset watchdog.
 * Assumes the design files are compiled first; the bench drives all ports.
 */
`include "wrw_defs.svh"
`default_nettype none

module test_wrw_watchdog;
    timeunit 1ns;
    timeprecision 1ps;

    // ---------------------------------------------------------------
    // Signals
    // ---------------------------------------------------------------
    // Short counts keep the run brief; tick and pulse expectations derive from them, wake ones from the full 514 cycles
    localparam int TICK = 16;
    localparam int RSTC = 10;
    localparam logic [11:0] CTRL = `WRW_CTRL_ADDR;
    localparam logic [11:0] STAT = `WRW_STAT_ADDR;
    logic core_clk, rst_b, psel, penable, pwrite, hw_mode_opt, halt_req, ext_wake;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, wd_rst_b, er, seen;
    logic [7:0] v;
    int fails, n_tests, seed, n, k;

    wrw_watchdog #(.TICK_CYC(TICK), .RST_CYC(RSTC)) wrw_watchdog_inst (
        .core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .hw_mode_opt(hw_mode_opt),
        .halt_req(halt_req), .ext_wake(ext_wake), .wd_rst_b(wd_rst_b));

    // ---------------------------------------------------------------
    // Tasks
    // ---------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Count left after whole decrement intervals since a write
    function automatic logic [31:0] exp_count(input logic [7:0] w, input int steps);
        return {24'h0, w - 8'(steps)};
    endfunction

    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge core_clk);
        penable <= 1'b1;
        // No cycle limit here: the bench watchdog ends a wait that never answers
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Outputs are looked at on the falling edge, clear of input updates
    task automatic wait_low(input int lim);
        seen = 1'b0;
        for (int i = 0; i < lim && !seen; i++) begin
            @(negedge core_clk);
            seen = (wd_rst_b === 1'b0);
        end
    endtask

    task automatic fire(input int lim);
        wait_low(lim);
        chk("reset pulse seen", 32'h1, {31'h0, seen});
        n = 0;
        while (wd_rst_b === 1'b0 && n < 100) begin
            n++;
            @(negedge core_clk);
        end
        chk("reset pulse length", RSTC, n);
    endtask

    task automatic do_reset();
        @(posedge core_clk);
        rst_b <= 1'b0;
        repeat (6) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (6) @(posedge core_clk);
    endtask

    task automatic complete_run();
        if (fails == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ---------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ---------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    initial begin
        #100000;
        fails++;
        complete_run();
    end

    initial begin
        seed = 73593;
        fails = 0;
        n_tests = 0;
        {rst_b, psel, penable, pwrite, hw_mode_opt, halt_req, ext_wake} = '0;
        paddr = '0;
        pwdata = '0;
        do_reset();
        apb(0, CTRL, 0);
        chk("ctrl reset", 32'h7F, rd);
        apb(0, STAT, 0);
        chk("status reset", 32'h0, rd);
        apb(1, STAT, 8'hFF);
        apb(0, 12'h03C, 0);
        chk("unmapped error", 32'h1, {31'h0, er});
        chk("unmapped data", 32'h0, rd);
        apb(0, STAT, 0);
        chk("status unwritten", 32'h0, rd);
        repeat (4) begin
            v = 8'h48 | (8'($random(seed)) & 8'h37);
            k = 1 + ($unsigned($random(seed)) % 3);
            apb(1, CTRL, v);
            wait_low(k * TICK + TICK / 2);
            apb(0, CTRL, 0);
            chk("count steps", exp_count(v, k), rd);
        end
        apb(1, CTRL, 8'h41);
        wait_low(3 * TICK + TICK / 2);
        chk("inactive no reset", 32'h0, {31'h0, seen});
        apb(0, CTRL, 0);
        chk("inactive count", 32'h3E, rd);
        repeat (3) begin
            apb(1, CTRL, 8'hC0 | 8'($random(seed)));
            wait_low(TICK / 2);
            chk("refresh no reset", 32'h0, {31'h0, seen});
        end
        apb(1, CTRL, 8'hC2);
        apb(1, CTRL, 8'h42);
        apb(0, CTRL, 0);
        chk("act sticky", 32'hC2, rd);
        wait_low(TICK + 8);
        chk("early reset", 32'h0, {31'h0, seen});
        fire(2 * TICK);
        do_reset();
        apb(0, CTRL, 0);
        chk("ctrl after reset", 32'h7F, rd);
        apb(1, CTRL, 8'h80 | (8'($random(seed)) & 8'h3F));
        fire(4);
        hw_mode_opt <= 1'b1;
        do_reset();
        apb(0, STAT, 0);
        chk("hw mode status", 32'h1, rd);
        apb(1, CTRL, 8'h41);
        wait_low(TICK + TICK / 2);
        chk("hw early reset", 32'h0, {31'h0, seen});
        fire(TICK + 8);
        hw_mode_opt <= 1'b0;
        do_reset();
        apb(1, CTRL, 8'hC1);
        halt_req <= 1'b1;
        apb(0, STAT, 0);
        chk("halt status", 32'h2, rd);
        wait_low(5 * TICK);
        chk("halt no reset", 32'h0, {31'h0, seen});
        apb(0, CTRL, 0);
        chk("halt frozen", 32'hC1, rd);
        @(posedge core_clk);
        ext_wake <= 1'b1;
        halt_req <= 1'b0;
        @(posedge core_clk);
        ext_wake <= 1'b0;
        apb(0, STAT, 0);
        chk("wake status", 32'h4, rd);
        wait_low(480);
        chk("wake no reset", 32'h0, {31'h0, seen});
        apb(0, CTRL, 0);
        chk("wake frozen", 32'hC1, rd);
        fire(70);
        apb(1, CTRL, 8'hC5);
        halt_req <= 1'b1;
        repeat (4) @(posedge core_clk);
        halt_req <= 1'b0;
        do_reset();
        apb(0, CTRL, 0);
        chk("halt reset ctrl", 32'h7F, rd);
        apb(0, STAT, 0);
        chk("halt reset status", 32'h0, rd);
        complete_run();
    end
endmodule // test_wrw_watchdog

`default_nettype wire
